// ### rtl/smsm_mode_fsm.sv
// Purpose: Operating-mode state machine with start-up sampling and restart policy.
// Assumes: rst_b is the power-on reset; pins are asynchronous to clk.
// Notes:   SPI words cross from the sclk domain by a toggle handshake.
`timescale 1ns/100ps
module smsm_mode_fsm
  import smsm_pkg::*;
#(
  parameter int unsigned RESET_DELAY_CYC = RESET_DELAY_CYCLES,
  parameter int unsigned LONG_WINDOW_CYC = LONG_WINDOW_CYCLES
) (
  // Core clock and power-on reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // SPI link from the microcontroller
  input  wire logic         spi_sclk,
  input  wire logic         spi_cs_b,
  input  wire logic         spi_mosi,
  // Supply and fault sense
  input  wire logic         main_supply_ok,
  input  wire logic         battery_ok,
  input  wire logic         main_supply_short,
  input  wire logic         severe_overtemp_shutdown,
  // Wake sources
  input  wire logic         wake_can,
  input  wire logic [2:0]   wake_lin,
  input  wire logic         wake_input_pin,
  // Fail output 3 / test strap, two-way
  input  wire logic         failout3_test_pin_in,
  output logic              failout3_test_pin_out,
  output logic              failout3_test_pin_oe,
  // Pins toward the system
  output logic              reset_output_pin_b,
  output logic              int_pin_b,
  output logic              failout1_pin_b,
  output logic              failsafe_input_active,
  // Supply and transceiver control
  output logic              main_supply_en,
  output logic              aux_supply_en,
  output logic [1:0]        can_mode,
  output logic [1:0]        lin_mode,
  // Software-visible state
  output logic [7:0]        system_status_scratch_reg,
  output smsm_status_t      status
);

  // ---------------- SPI link domain ----------------
  logic [3:0]  bit_cnt_reg;
  logic [14:0] shift_reg;
  smsm_cmd_t   word_reg;
  logic        word_tog_reg;

  // Bit counter restarts with each frame; chip select ends a frame
  always_ff @(posedge spi_sclk or posedge spi_cs_b) begin
    if (spi_cs_b) begin
      bit_cnt_reg <= 4'h0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // Word is held until the next frame, long after the toggle settles
  always_ff @(posedge spi_sclk or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg    <= 15'h0000;
      word_reg     <= '0;
      word_tog_reg <= 1'b0;
    end else if (!spi_cs_b) begin
      shift_reg <= {shift_reg[13:0], spi_mosi};
      if (bit_cnt_reg == SPI_LAST) begin
        word_reg     <= smsm_cmd_t'({shift_reg, spi_mosi});
        word_tog_reg <= ~word_tog_reg;
      end
    end
  end

  // ---------------- Synchronisers ----------------
  localparam int unsigned NSYNC = 7;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [1:0]       hist_reg;
  wire              wake_raw = wake_can | (|wake_lin) | wake_input_pin;
  wire [NSYNC-1:0]  pins_raw = {word_tog_reg, failout3_test_pin_in, severe_overtemp_shutdown,
                                main_supply_short, battery_ok, main_supply_ok, wake_raw};

  // Two stages before anything reads a pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      hist_reg  <= 2'h0;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      hist_reg  <= {sync2_reg[6], sync2_reg[0]};
    end
  end

  wire s_wake    = sync2_reg[0];
  wire s_sup_ok  = sync2_reg[1];
  wire s_bat_ok  = sync2_reg[2];
  wire s_short   = sync2_reg[3];
  wire s_ot      = sync2_reg[4];
  wire s_test    = sync2_reg[5];
  wire wake_evt  = s_wake & ~hist_reg[0];
  wire cmd_valid = sync2_reg[6] ^ hist_reg[1];

  // ---------------- Core state ----------------
  smsm_state_t state_reg, state_next;
  logic [TMR_W-1:0] tmr_reg;
  logic [TMR_W-1:0] wd_reg;
  logic [INT_W-1:0] int_reg;
  logic       released_reg;
  logic       test_reg;
  logic       dev_lock_reg;
  logic       miss_reg;
  logic [1:0] rst_cnt_reg;
  logic       cfg_state_reg;
  logic       fo_test_reg;
  logic       limit_reg;
  logic       fail_act_reg;
  logic       spi_fail_reg;
  logic       wd_fail_reg;
  logic       uv_reg;
  logic [1:0] mode_reg;
  logic       aux_reg;
  logic [1:0] can_reg;
  logic [1:0] lin_reg;
  logic [7:0] scratch_reg;

  // Command decode
  wire        is_wr     = cmd_valid & word_reg.write;
  wire        wr_mode   = is_wr & (word_reg.addr == ADDR_MODE_CTRL);
  wire        wr_wd     = is_wr & (word_reg.addr == ADDR_WATCHDOG_CONTROL_REG);
  wire        wr_scr    = is_wr & (word_reg.addr == ADDR_SCRATCH);
  wire        wr_clr    = is_wr & (word_reg.addr == ADDR_STAT_CLR);
  wire        wr_bus    = is_wr & (word_reg.addr == ADDR_BUS_CTRL);
  wire        wr_hw     = is_wr & (word_reg.addr == ADDR_HARDWARE_CONTROL_REG);
  wire [1:0]  req_mode  = word_reg.data[1:0];
  wire        req_soft  = wr_mode & (req_mode == MODE_SOFT_RST);
  wire        req_norm  = wr_mode & (req_mode == MODE_NORMAL);

  // SPI is only interpreted while the controller is supplied and out of reset
  wire in_init    = (state_reg == ST_INIT);
  wire in_normal  = (state_reg == ST_NORMAL);
  wire in_stop    = (state_reg == ST_STOP);
  wire spi_live   = (in_init & released_reg) | in_normal | in_stop;

  // Stop mode allows only a short list of writes
  wire stop_ok    = req_norm | req_soft | wr_wd | wr_scr | wr_clr;
  wire stop_rej   = in_stop & is_wr & ~stop_ok;
  wire stop_sleep = in_stop & wr_mode & (req_mode == MODE_SLEEP);
  wire wr_ok      = spi_live & is_wr & ~stop_rej;
  wire cfg_ok     = wr_ok & ~in_stop;

  // Watchdog runs after release, halted in development mode
  wire dev_mode   = test_reg & ~dev_lock_reg;
  wire wd_run     = ((in_init & released_reg) | in_normal | in_stop) & ~dev_mode;
  wire wd_trig    = wr_ok & wr_wd;
  wire wd_expire  = wd_run & (wd_reg == '0) & ~wd_trig;
  wire limited    = limit_reg & (rst_cnt_reg == WD_RST_LIMIT);
  wire wd_restart = wd_expire & (cfg_state_reg | miss_reg) & ~limited;

  // Supply fault outside the power-up ramp
  wire uv_evt     = ~s_sup_ok & ~(in_init & ~s_bat_ok);
  wire tmr_done   = (tmr_reg == TMR_W'(RESET_DELAY_CYC - 1));
  wire fault_fs   = s_ot | s_short;

  // Next operating mode
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_INIT: begin
        if (fault_fs && released_reg) begin
          state_next = ST_FAILSAFE;
        end else if (wd_restart) begin
          state_next = ST_RESTART;
        end else if (spi_live && cmd_valid && !req_soft) begin
          state_next = ST_NORMAL;
        end
      end
      ST_NORMAL, ST_STOP: begin
        if (fault_fs) begin
          state_next = ST_FAILSAFE;
        end else if (wd_restart || uv_evt || stop_sleep) begin
          state_next = ST_RESTART;
        end else if (req_soft) begin
          state_next = ST_INIT;
        end else if (wr_ok && wr_mode) begin
          state_next = (req_mode == MODE_SLEEP) ? ST_SLEEP :
                       (req_mode == MODE_STOP)  ? ST_STOP  : ST_NORMAL;
        end
      end
      ST_SLEEP: begin
        if (wake_evt) begin
          state_next = ST_RESTART;
        end
      end
      ST_RESTART: begin
        if (s_sup_ok && tmr_done) begin
          state_next = ST_NORMAL;
        end
      end
      ST_FAILSAFE: begin
        if (wake_evt && !s_ot) begin
          state_next = ST_RESTART;
        end
      end
    endcase
  end

  wire enter_normal = (state_next == ST_NORMAL) & ~in_normal & ~in_stop;
  wire enter_init   = (state_next == ST_INIT) & ~in_init;

  // State and delay timer; timer restarts on every mode change
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_INIT;
      tmr_reg   <= '0;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg || !s_sup_ok || tmr_done) begin
        tmr_reg <= '0;
      end else if (!released_reg || state_reg == ST_RESTART) begin
        tmr_reg <= tmr_reg + 1'b1;
      end
    end
  end

  // Start-up: sample strap during the delay, then release reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      released_reg <= 1'b0;
      test_reg     <= 1'b0;
      dev_lock_reg <= 1'b0;
    end else begin
      if (enter_init) begin
        released_reg <= 1'b0;
      end else if (in_init && s_sup_ok && tmr_done) begin
        released_reg <= 1'b1;
      end
      if (in_init && !released_reg && s_sup_ok) begin
        test_reg <= ~s_test & ~dev_lock_reg;
      end
      if (req_soft && spi_live) begin
        dev_lock_reg <= 1'b1;
      end
    end
  end

  // Watchdog counter, miss history and consecutive reset count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wd_reg      <= TMR_W'(LONG_WINDOW_CYC - 1);
      miss_reg    <= 1'b0;
      rst_cnt_reg <= 2'h0;
    end else begin
      if (!wd_run || wd_trig || wd_expire) begin
        wd_reg <= TMR_W'(LONG_WINDOW_CYC - 1);
      end else begin
        wd_reg <= wd_reg - 1'b1;
      end
      if (wd_trig) begin
        miss_reg    <= 1'b0;
        rst_cnt_reg <= 2'h0;
      end else if (wd_expire) begin
        miss_reg <= ~wd_restart;
        if (wd_restart && rst_cnt_reg != WD_RST_LIMIT) begin
          rst_cnt_reg <= rst_cnt_reg + 2'h1;
        end
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_state_reg <= RESTART_CFG_RST;
      fo_test_reg   <= 1'b0;
      limit_reg     <= 1'b0;
      scratch_reg   <= 8'h00;
      aux_reg       <= 1'b0;
      can_reg       <= XCVR_OFF;
      lin_reg       <= XCVR_OFF;
    end else begin
      if (cfg_ok && wr_hw) begin
        cfg_state_reg <= word_reg.data[HW_RESTART_CFG_BIT];
        fo_test_reg   <= word_reg.data[HW_FAILOUT_TEST_BIT] & in_normal;
      end else if (!in_normal) begin
        fo_test_reg <= 1'b0;
      end
      if (cfg_ok && wr_wd) begin
        limit_reg <= word_reg.data[WD_RESET_LIMIT_BIT];
      end
      if (wr_ok && wr_scr) begin
        scratch_reg <= word_reg.data;
      end
      if (enter_normal) begin
        aux_reg <= 1'b0;
        can_reg <= (in_init || can_reg == XCVR_OFF) ? XCVR_OFF : XCVR_WAKE;
        lin_reg <= (in_init || lin_reg == XCVR_OFF) ? XCVR_OFF : XCVR_WAKE;
      end else if (cfg_ok && wr_bus) begin
        aux_reg <= word_reg.data[BUS_AUX_BIT];
        can_reg <= word_reg.data[BUS_CAN_LSB +: 2];
        lin_reg <= word_reg.data[BUS_LIN_LSB +: 2];
      end
    end
  end

  // Status flags: a new event wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      spi_fail_reg <= 1'b0;
      wd_fail_reg  <= 1'b0;
      uv_reg       <= 1'b0;
      fail_act_reg <= 1'b0;
      mode_reg     <= MODE_NORMAL;
    end else begin
      spi_fail_reg <= (stop_rej | stop_sleep) | (spi_fail_reg & ~(wr_ok & wr_clr));
      wd_fail_reg  <= wd_expire | (wd_fail_reg & ~(wr_ok & wr_clr));
      uv_reg       <= uv_evt | (uv_reg & ~(wr_ok & wr_clr));
      if (wd_restart || state_next == ST_FAILSAFE) begin
        fail_act_reg <= 1'b1;
      end else if (enter_init) begin
        fail_act_reg <= 1'b0;
      end
      if (state_reg == ST_RESTART || enter_init) begin
        mode_reg <= MODE_NORMAL;
      end else if (wr_ok && wr_mode && !req_soft) begin
        mode_reg <= req_mode;
      end
    end
  end

  // Interrupt pulse on wake while awake; Init drops wakes unstored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int_reg <= '0;
    end else if (wake_evt && (in_normal || in_stop)) begin
      int_reg <= INT_W'(INT_PULSE_CYCLES);
    end else if (int_reg != '0) begin
      int_reg <= int_reg - 1'b1;
    end
  end

  // Pin drive; the strap pin is driven only outside Init while a fail output is active
  wire failout_test_on = fail_act_reg | fo_test_reg;
  assign reset_output_pin_b    = in_normal | in_stop | (in_init & released_reg);
  assign int_pin_b             = (int_reg == '0);
  assign failout1_pin_b        = ~failout_test_on;
  assign failout3_test_pin_out = ~failout_test_on;
  assign failout3_test_pin_oe  = ~in_init & failout_test_on;
  assign failsafe_input_active = ~fail_act_reg;
  assign main_supply_en        = (state_reg != ST_SLEEP) & (state_reg != ST_FAILSAFE);
  assign aux_supply_en         = aux_reg & (in_normal | in_stop);
  assign can_mode              = can_reg;
  assign lin_mode              = lin_reg;
  assign system_status_scratch_reg = scratch_reg;

  // Status bundle
  assign status = '{spi_fail: spi_fail_reg, wd_fail: wd_fail_reg,
                    main_supply_undervoltage_flag: uv_reg, test_flag: test_reg,
                    restart_config_state: cfg_state_reg, dev_mode: dev_mode,
                    mode_field: mode_reg};

endmodule : smsm_mode_fsm

// ### common/smsm_pkg.sv
// Purpose: Shared constants and carriers for the mode state machine.
// Assumes: Core clock of 10 MHz; SPI words are 16 bits, MSB first.
// Notes:   Counts derive from times in microseconds.
package smsm_pkg;

  // Core clock
  localparam int unsigned CLK_MHZ = 10;

  // Times in microseconds and their cycle counts
  localparam int unsigned RESET_DELAY_US     = 10000;
  localparam int unsigned RESET_DELAY_CYCLES = RESET_DELAY_US * CLK_MHZ;
  localparam int unsigned LONG_WINDOW_US     = 200000;
  localparam int unsigned LONG_WINDOW_CYCLES = LONG_WINDOW_US * CLK_MHZ;
  localparam int unsigned INT_PULSE_US       = 100;
  localparam int unsigned INT_PULSE_CYCLES   = INT_PULSE_US * CLK_MHZ;

  // Counter widths
  localparam int unsigned TMR_W = 24;
  localparam int unsigned INT_W = 12;

  // SPI word layout: write flag, 7-bit address, 8-bit data
  localparam int unsigned SPI_BITS  = 16;
  localparam logic [3:0]  SPI_LAST  = 4'hF;

  // Command addresses
  localparam logic [6:0] ADDR_MODE_CTRL = 7'h01;
  localparam logic [6:0] ADDR_SCRATCH   = 7'h02;
  localparam logic [6:0] ADDR_WATCHDOG_CONTROL_REG   = 7'h03;
  localparam logic [6:0] ADDR_BUS_CTRL  = 7'h04;
  localparam logic [6:0] ADDR_HARDWARE_CONTROL_REG   = 7'h0E;
  localparam logic [6:0] ADDR_STAT_CLR  = 7'h40;

  // Mode field encodings (data bits 1:0 of mode control)
  localparam logic [1:0] MODE_NORMAL   = 2'h0;
  localparam logic [1:0] MODE_SLEEP    = 2'h1;
  localparam logic [1:0] MODE_STOP     = 2'h2;
  localparam logic [1:0] MODE_SOFT_RST = 2'h3;

  // Field positions
  localparam int unsigned HW_RESTART_CFG_BIT  = 0;
  localparam int unsigned HW_FAILOUT_TEST_BIT = 1;
  localparam int unsigned WD_RESET_LIMIT_BIT  = 0;
  localparam int unsigned BUS_AUX_BIT         = 0;
  localparam int unsigned BUS_CAN_LSB         = 1;
  localparam int unsigned BUS_LIN_LSB         = 3;

  // Transceiver modes
  localparam logic [1:0] XCVR_OFF  = 2'h0;
  localparam logic [1:0] XCVR_WAKE = 2'h1;

  // Reset values
  localparam logic       RESTART_CFG_RST = 1'b1;
  localparam logic [1:0] WD_RST_LIMIT    = 2'h3;

  // Operating modes
  typedef enum logic [2:0] {
    ST_INIT, ST_NORMAL, ST_STOP, ST_SLEEP, ST_RESTART, ST_FAILSAFE
  } smsm_state_t;

  // One received SPI word
  typedef struct packed {
    logic       write;
    logic [6:0] addr;
    logic [7:0] data;
  } smsm_cmd_t;

  // Status seen by software
  typedef struct packed {
    logic       spi_fail;
    logic       wd_fail;
    logic       main_supply_undervoltage_flag;
    logic       test_flag;
    logic       restart_config_state;
    logic       dev_mode;
    logic [1:0] mode_field;
  } smsm_status_t;

endpackage : smsm_pkg

// ### verif/smsm_mode_fsm_sva.sv
// Purpose: Port-level assertions for the mode state machine.
// Assumes: Only the core clock domain is watched.
// Notes:   Bound to every instance of smsm_mode_fsm.
`timescale 1ns/100ps
module smsm_mode_fsm_sva
  import smsm_pkg::*;
#(
  parameter int unsigned RESET_DELAY_CYC = RESET_DELAY_CYCLES
) (
  // Clock and reset
  input wire logic         clk,
  input wire logic         rst_b,
  // Sense inputs
  input wire logic         main_supply_ok,
  input wire logic         battery_ok,
  input wire logic         severe_overtemp_shutdown,
  // Observed outputs
  input wire logic         reset_output_pin_b,
  input wire logic         int_pin_b,
  input wire logic         failout1_pin_b,
  input wire logic         main_supply_en,
  input wire logic         aux_supply_en,
  input wire smsm_status_t status
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  int unsigned ok_cnt;
  int unsigned low_cnt;
  logic        powered;
  // Run lengths; powered marks the first reset release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ok_cnt  <= '0;
      low_cnt <= '0;
      powered <= 1'h0;
    end else begin
      ok_cnt  <= main_supply_ok ? ok_cnt + 1 : '0;
      low_cnt <= int_pin_b ? '0 : low_cnt + 1;
      powered <= powered | reset_output_pin_b;
    end
  end
  sequence release_s; $rose(reset_output_pin_b); endsequence
  sequence int_start_s; $fell(int_pin_b); endsequence
  sequence overtemp_held_s; severe_overtemp_shutdown [*8]; endsequence
  reset_delay_a: assert property (release_s |-> ok_cnt >= RESET_DELAY_CYC)
    else $error("reset released before supply settled");
  reset_hold_a: assert property (!main_supply_ok [*4] |-> !reset_output_pin_b)
    else $error("reset high with supply low");
  mode_clear_a: assert property (release_s ##0 status.wd_fail |-> status.mode_field == 2'h0)
    else $error("mode field not cleared by restart");
  aux_off_a: assert property (release_s |-> !aux_supply_en)
    else $error("aux supply on at mode entry");
  ramp_quiet_a: assert property (!powered && !main_supply_ok && !battery_ok
      |-> !status.main_supply_undervoltage_flag && failout1_pin_b)
    else $error("flag or fail output during ramp");
  int_len_a: assert property ($rose(int_pin_b) |-> low_cnt == INT_PULSE_CYCLES)
    else $error("interrupt pulse length wrong");
  int_src_a: assert property (int_start_s |-> reset_output_pin_b)
    else $error("interrupt while reset active");
  fs_enter_a: assert property (overtemp_held_s |-> !main_supply_en)
    else $error("main supply on during overtemperature");
  fs_hold_a: assert property (overtemp_held_s ##0 !main_supply_en |=> !main_supply_en)
    else $error("fail-safe left during overtemperature");
  dev_wd_a: assert property (status.dev_mode |=> !$rose(status.wd_fail))
    else $error("watchdog failure in development mode");
  wd_supply_a: assert property ($rose(status.wd_fail) |-> main_supply_en [*4])
    else $error("main supply dropped on watchdog failure");
endmodule : smsm_mode_fsm_sva
bind smsm_mode_fsm smsm_mode_fsm_sva #(.RESET_DELAY_CYC(RESET_DELAY_CYC)) i_smsm_mode_fsm_sva (
  .clk(clk), .rst_b(rst_b), .main_supply_ok(main_supply_ok), .battery_ok(battery_ok),
  .severe_overtemp_shutdown(severe_overtemp_shutdown), .reset_output_pin_b(reset_output_pin_b),
  .int_pin_b(int_pin_b), .failout1_pin_b(failout1_pin_b), .main_supply_en(main_supply_en),
  .aux_supply_en(aux_supply_en), .status(status));

// ### verif/smsm_mcu_model.sv
// Purpose: Microcontroller side of the SPI link.
// Assumes: 125 ns serial clock, mode 0, MSB first.
// Notes:   Serial clock stands still between frames.
`timescale 1ns/100ps
module smsm_mcu_model
  import smsm_pkg::*;
(
  // SPI toward the device
  output logic spi_sclk,
  output logic spi_cs_b,
  output logic spi_mosi
);
  initial begin
    spi_sclk = 1'h0;
    spi_cs_b = 1'h1;
    spi_mosi = 1'h0;
  end
  // Whole 16-bit word; odd start offset keeps phase unrelated to clk
  task automatic send(input smsm_cmd_t cmd);
    logic [15:0] w;
    w = cmd;
    #37;
    spi_cs_b = 1'h0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = w[i];
      #62.5 spi_sclk = 1'h1;
      #62.5 spi_sclk = 1'h0;
    end
    spi_mosi = ~w[0]; // Released line must not look held
    #62.5 spi_cs_b = 1'h1;
  endtask : send
endmodule : smsm_mcu_model

// ### verif/testbench.sv
// Purpose: Self-checking bench for the mode state machine.
// Assumes: Short reset delay and window parameters.
// Notes:   Inputs other than the SPI lines change on the falling clock edge.
`timescale 1ns/100ps
module testbench;
  import smsm_pkg::*;
  localparam int unsigned RD = 20;
  localparam int unsigned LW = 200;
  logic clk, rst_b, spi_sclk, spi_cs_b, spi_mosi, main_supply_ok, battery_ok;
  logic main_supply_short, severe_overtemp_shutdown, wake_can, wake_input_pin, strap_drv;
  logic [2:0] wake_lin;
  logic failout3_test_pin_out, failout3_test_pin_oe, reset_output_pin_b, int_pin_b;
  logic failout1_pin_b, failsafe_input_active, main_supply_en, aux_supply_en;
  logic [1:0] can_mode, lin_mode;
  logic [7:0] system_status_scratch_reg;
  smsm_status_t status;
  wire logic failout3_test_pin_in;
  int fail_count = 0;
  int n_tests = 0;
  // Strap level: device drive wins, else the bench strap
  assign failout3_test_pin_in = failout3_test_pin_oe ? failout3_test_pin_out : strap_drv;
  smsm_mode_fsm #(.RESET_DELAY_CYC(RD), .LONG_WINDOW_CYC(LW)) i_smsm_mode_fsm (
    .clk(clk), .rst_b(rst_b), .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi),
    .main_supply_ok(main_supply_ok), .battery_ok(battery_ok),
    .main_supply_short(main_supply_short), .severe_overtemp_shutdown(severe_overtemp_shutdown),
    .wake_can(wake_can), .wake_lin(wake_lin), .wake_input_pin(wake_input_pin),
    .failout3_test_pin_in(failout3_test_pin_in), .failout3_test_pin_out(failout3_test_pin_out),
    .failout3_test_pin_oe(failout3_test_pin_oe), .reset_output_pin_b(reset_output_pin_b),
    .int_pin_b(int_pin_b), .failout1_pin_b(failout1_pin_b),
    .failsafe_input_active(failsafe_input_active), .main_supply_en(main_supply_en),
    .aux_supply_en(aux_supply_en), .can_mode(can_mode), .lin_mode(lin_mode),
    .system_status_scratch_reg(system_status_scratch_reg), .status(status));
  smsm_mcu_model i_smsm_mcu_model (.spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b),
    .spi_mosi(spi_mosi));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // Bounded wait; the caller judges the level reached
  task automatic wait_lvl(ref logic s, input logic lvl, input int max);
    for (int i = 0; i < max && s !== lvl; i++) @(negedge clk);
  endtask : wait_lvl
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_smsm_mcu_model.send({1'h1, a, d});
    cyc(8);
  endtask : wr
  // Mask order: lin[2:0], wake pin, can
  task automatic wake(input logic [4:0] m);
    {wake_lin, wake_input_pin, wake_can} = m;
    cyc(6);
    {wake_lin, wake_input_pin, wake_can} = 5'h00;
    cyc(2);
  endtask : wake
  task automatic t_power_up(input logic strap);
    rst_b = 1'h0;
    main_supply_ok = 1'h0;
    battery_ok = 1'h0;
    strap_drv = strap;
    cyc(8);
    rst_b = 1'h1;
    cyc(6);
    chk(reset_output_pin_b, 8'h00);
    chk({failout1_pin_b, status.main_supply_undervoltage_flag}, 8'h02);
    main_supply_ok = 1'h1;
    battery_ok = 1'h1;
    cyc(RD - 1);
    chk(reset_output_pin_b, 8'h00);
    wait_lvl(reset_output_pin_b, 1'h1, 10);
    chk(reset_output_pin_b, 8'h01);
    chk({aux_supply_en, can_mode, lin_mode, failout3_test_pin_oe}, 8'h00);
    chk(status.test_flag, {7'h00, ~strap});
  endtask : t_power_up
  task automatic t_normal;
    wake(5'h01);
    chk(int_pin_b, 8'h01);
    wr(7'h7F, 8'hA5);
    chk({failout1_pin_b, failsafe_input_active}, 8'h03);
    wr(ADDR_HARDWARE_CONTROL_REG, 8'h03);
    chk({failout1_pin_b, failout3_test_pin_out, failout3_test_pin_oe}, 8'h01);
    wr(ADDR_HARDWARE_CONTROL_REG, 8'h01);
    chk({failout1_pin_b, failout3_test_pin_out, failout3_test_pin_oe}, 8'h06);
    wr(ADDR_BUS_CTRL, 8'h0B);
    chk({aux_supply_en, can_mode, lin_mode}, 8'h15);
    wake(5'h04);
    chk({int_pin_b, reset_output_pin_b, status.mode_field}, 8'h04);
    // Keep feeding the watchdog until the pulse ends
    for (int i = 0; i < 45 && int_pin_b !== 1'h1; i++) wr(ADDR_WATCHDOG_CONTROL_REG, 8'h00);
    chk(int_pin_b, 8'h01);
  endtask : t_normal
  task automatic t_stop_wd;
    wr(ADDR_MODE_CTRL, {6'h00, MODE_STOP});
    chk(status.mode_field, {6'h00, MODE_STOP});
    wr(ADDR_BUS_CTRL, 8'h00);
    chk({aux_supply_en, status.spi_fail}, 8'h03);
    wr(ADDR_SCRATCH, 8'h5A);
    chk(system_status_scratch_reg, 8'h5A);
    wr(ADDR_STAT_CLR, 8'h00);
    chk(status.spi_fail, 8'h00);
    wait_lvl(reset_output_pin_b, 1'h0, LW + 20);
    chk({main_supply_en, failout1_pin_b, status.wd_fail}, 8'h05);
    wait_lvl(reset_output_pin_b, 1'h1, RD + 10);
    chk({reset_output_pin_b, status.mode_field}, 8'h04);
    chk({aux_supply_en, can_mode, lin_mode}, 8'h05);
  endtask : t_stop_wd
  task automatic t_stop_sleep;
    wr(ADDR_MODE_CTRL, {6'h00, MODE_STOP});
    wr(ADDR_MODE_CTRL, {6'h00, MODE_SLEEP});
    chk({reset_output_pin_b, status.spi_fail}, 8'h01);
    wait_lvl(reset_output_pin_b, 1'h1, RD + 10);
    chk({main_supply_en, status.mode_field}, 8'h04);
    wr(ADDR_MODE_CTRL, {6'h00, MODE_SLEEP});
    chk({main_supply_en, reset_output_pin_b, status.mode_field}, 8'h01);
    wake(5'h01);
    wait_lvl(reset_output_pin_b, 1'h1, RD + 10);
    chk({main_supply_en, reset_output_pin_b}, 8'h03);
  endtask : t_stop_sleep
  task automatic t_second_miss;
    wr(ADDR_HARDWARE_CONTROL_REG, 8'h00);
    chk(status.restart_config_state, 8'h00);
    wait_lvl(reset_output_pin_b, 1'h0, LW + 20);
    chk(reset_output_pin_b, 8'h01);
    wait_lvl(reset_output_pin_b, 1'h0, LW + 20);
    chk(reset_output_pin_b, 8'h00);
    wait_lvl(reset_output_pin_b, 1'h1, RD + 10);
    // Three restarts with the limit set, then a miss must not reset
    wr(ADDR_HARDWARE_CONTROL_REG, 8'h01);
    wr(ADDR_WATCHDOG_CONTROL_REG, 8'h01);
    repeat (3) begin
      wait_lvl(reset_output_pin_b, 1'h0, LW + 20);
      wait_lvl(reset_output_pin_b, 1'h1, RD + 10);
    end
    wr(ADDR_STAT_CLR, 8'h00);
    wait_lvl(reset_output_pin_b, 1'h0, LW + 20);
    chk({reset_output_pin_b, status.wd_fail}, 8'h03);
  endtask : t_second_miss
  task automatic t_failsafe;
    severe_overtemp_shutdown = 1'h1;
    wait_lvl(main_supply_en, 1'h0, 10);
    wake(5'h02);
    chk({main_supply_en, reset_output_pin_b}, 8'h00);
    severe_overtemp_shutdown = 1'h0;
    cyc(4);
    wake(5'h10);
    wait_lvl(reset_output_pin_b, 1'h1, RD + 20);
    chk({main_supply_en, reset_output_pin_b}, 8'h03);
    // Supply dip in Normal: reset low, flag kept after recovery
    main_supply_ok = 1'h0;
    cyc(4);
    chk({reset_output_pin_b, status.main_supply_undervoltage_flag}, 8'h01);
    main_supply_ok = 1'h1;
    wait_lvl(reset_output_pin_b, 1'h1, RD + 10);
    chk({reset_output_pin_b, status.main_supply_undervoltage_flag}, 8'h03);
  endtask : t_failsafe
  task automatic t_dev;
    t_power_up(1'h0);
    wr(ADDR_SCRATCH, 8'h3C);
    chk(status.dev_mode, 8'h01);
    cyc(2 * LW);
    chk({reset_output_pin_b, status.wd_fail}, 8'h02);
    wr(ADDR_MODE_CTRL, {6'h00, MODE_SOFT_RST});
    cyc(RD + 10);
    chk(status.dev_mode, 8'h00);
  endtask : t_dev
  // Watchdog against a hung sequence
  initial begin
    #1000000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    {main_supply_short, severe_overtemp_shutdown} = 2'h0;
    {wake_lin, wake_input_pin, wake_can} = 5'h00;
    t_power_up(1'h1);
    t_normal();
    t_stop_wd();
    t_stop_sleep();
    t_second_miss();
    t_failsafe();
    t_dev();
    tally_and_finish();
  end
endmodule : testbench
